// ---- design/wit_core.sv ----
// watch and interval timer: mode register, prescaler, 5-bit counter, interrupts
`include "wit_map.svh"

module wit_core
	import wit_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   mode_wr,
	input  wire logic [`WIT_MODE_W-1:0] mode_wdata,
	input  wire logic                   sub_clk,
	output logic      [`WIT_MODE_W-1:0] mode_rdata,
	output logic      [`WIT_PRESC_W-1:0] presc_value,
	output logic      [`WIT_CNT_W-1:0]  cnt_value,
	output logic                        watch_interrupt,
	output logic                        interval_interrupt
);

	logic [`WIT_MODE_W-1:0] watch_mode_reg;
	logic                   global_operation_enable;
	logic                   counter_run_bit;
	wit_wsel_t              wsel;
	logic [2:0]             isel;
	logic                   clock_source_select;
	logic                   div_tick;
	logic                   sub_q_reg;
	logic                   sub_edge;
	logic                   watch_tick;
	wit_presc_t             presc_reg;
	wit_cnt_t               cnt_reg;
	wit_presc_t             imask;
	logic                   tap9;
	logic                   watch_fire;
	logic                   interval_fire;
	logic                   watch_interrupt_reg;
	logic                   interval_interrupt_reg;

	// mode register, plain port write; reset gives stopped, peripheral clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			watch_mode_reg <= `WIT_MODE_RESET;
		else if (mode_wr)
			watch_mode_reg <= mode_wdata;
	end

	// field decode
	assign global_operation_enable = watch_mode_reg[`WIT_BIT_GLOBAL_EN];
	assign counter_run_bit         = watch_mode_reg[`WIT_BIT_RUN];
	assign wsel                    = wit_wsel_t'(watch_mode_reg[`WIT_BIT_WSEL_HI:`WIT_BIT_WSEL_LO]);
	assign isel                    = watch_mode_reg[`WIT_BIT_ISEL_HI:`WIT_BIT_ISEL_LO];
	assign clock_source_select     = watch_mode_reg[`WIT_BIT_CLK_SRC];
	assign mode_rdata              = watch_mode_reg;

	// peripheral clock divided by 128; held in phase while stopped
	wit_tick_div #(
		.DIV   (`WIT_PRS_DIV),
		.CNT_W (`WIT_PRS_DIV_W)
	) u_prs_div (
		.clk   (clk),
		.rst_n (rst_n),
		.clr   (!global_operation_enable),
		.tick  (div_tick)
	);

	// subsystem clock arrives as a synchronous level; its rising edge is a tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sub_q_reg <= 1'b0;
		else
			sub_q_reg <= sub_clk;
	end

	assign sub_edge = sub_clk && !sub_q_reg;

	// watch clock enable: every period below is counted in these ticks
	assign watch_tick = clock_source_select ? sub_edge : div_tick;

	// 11-bit prescaler: runs on global enable alone, shared by both functions
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			presc_reg <= '0;
		else if (!global_operation_enable)
			presc_reg <= '0;
		else if (watch_tick)
			presc_reg <= presc_reg + wit_presc_t'(1);
	end

	// prescaler 2^9 output feeds the 5-bit counter
	assign tap9 = watch_tick && (&presc_reg[`WIT_TAP_COUNTER-1:0]);

	// 5-bit counter; run cleared alone restarts only this, prescaler keeps phase,
	// so the first watch interrupt afterwards may be off by up to 2^9 ticks
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= '0;
		else if (!global_operation_enable || !counter_run_bit)
			cnt_reg <= '0;
		else if (tap9)
			cnt_reg <= cnt_reg + wit_cnt_t'(1);
	end

	// watch period select; long periods via counter overflow, short via taps
	always_comb
	begin
		case (wsel)
			WIT_WP_2P14:
				watch_fire = tap9 && (cnt_reg == `WIT_CNT_END_14);
			WIT_WP_2P13:
				watch_fire = tap9 && (cnt_reg[3:0] == `WIT_CNT_END_13);
			WIT_WP_2P5:
				watch_fire = watch_tick && (&presc_reg[`WIT_TAP_LONG-1:0]);
			WIT_WP_2P4:
				watch_fire = watch_tick && (&presc_reg[`WIT_TAP_SHORT-1:0]);
			default:
				watch_fire = 1'b0;
		endcase
	end

	// interval tap mask: 2^(4+isel) ticks, doubling per step
	assign imask = wit_presc_t'((12'h001 << (`WIT_ITAP_BASE + 32'(isel))) - 12'h001);

	// interval fires each time the low prescaler bits wrap
	assign interval_fire = watch_tick && ((presc_reg & imask) == imask);

	// interrupt pulses: one clock, in the cycle after the watch tick that completes a period;
	// gating by the enables keeps stopped timers silent (first period may be short)
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			watch_interrupt_reg <= 1'b0;
		else
			watch_interrupt_reg <= watch_fire && global_operation_enable
				&& counter_run_bit;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			interval_interrupt_reg <= 1'b0;
		else
			interval_interrupt_reg <= interval_fire && global_operation_enable;
	end

	assign watch_interrupt    = watch_interrupt_reg;
	assign interval_interrupt = interval_interrupt_reg;
	assign presc_value        = presc_reg;
	assign cnt_value          = cnt_reg;

	// checks on the timer behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	presc_stop_a: assert property (
		!global_operation_enable |=> presc_reg == '0)
		else $error("prescaler not cleared while disabled");

	cnt_restart_a: assert property (
		global_operation_enable && !counter_run_bit && watch_tick
		|=> cnt_reg == '0 && presc_reg == $past(presc_reg) + wit_presc_t'(1))
		else $error("zero-second restart disturbed prescaler or left counter");

	cnt_clear_a: assert property (
		!counter_run_bit |=> cnt_reg == '0)
		else $error("counter not cleared when run bit low");

	watch_gate_a: assert property (
		watch_interrupt |-> $past(global_operation_enable) && $past(counter_run_bit))
		else $error("watch interrupt while stopped");

	intv_gate_a: assert property (
		interval_interrupt |-> $past(global_operation_enable) && $past(watch_tick))
		else $error("interval interrupt without enable or tick");

	intv_period_a: assert property (
		interval_interrupt |-> ($past(presc_reg) & $past(imask)) == $past(imask))
		else $error("interval interrupt off its tap");

	watch_long_a: assert property (
		watch_interrupt && $past(wsel) == WIT_WP_2P14
		|-> $past(cnt_reg) == 5'h1F && $past(presc_reg[8:0]) == 9'h1FF)
		else $error("long watch period not from counter overflow");

	watch_short_a: assert property (
		watch_interrupt && $past(wsel) == WIT_WP_2P4 |-> $past(presc_reg[3:0]) == 4'hF)
		else $error("short watch period not from tap");

	pulse_single_a: assert property (
		watch_interrupt || interval_interrupt
		|=> !(watch_interrupt && $past(watch_interrupt))
		&& !(interval_interrupt && $past(interval_interrupt)))
		else $error("interrupt wider than one clock");

	// subsystem ticks only where the level input was seen rising
	sub_tick_a: assert property (
		clock_source_select && watch_tick |-> sub_clk && !$past(sub_clk))
		else $error("subsystem tick without rising edge");

	// divided peripheral tick is never followed by another within 8 clocks
	div_gap_a: assert property (
		div_tick |=> !div_tick [*8])
		else $error("divided tick too close to the previous one");

	// while enabled, prescaler only moves on a watch tick
	presc_hold_a: assert property (
		global_operation_enable && !watch_tick |=> presc_reg == $past(presc_reg))
		else $error("prescaler moved without tick");

	presc_inc_a: assert property (
		global_operation_enable && watch_tick
		|=> presc_reg == $past(presc_reg) + wit_presc_t'(1))
		else $error("prescaler missed a tick");

	// counter steps once per 2^9 tap, holds otherwise
	cnt_hold_a: assert property (
		global_operation_enable && counter_run_bit && !tap9 |=> cnt_reg == $past(cnt_reg))
		else $error("counter moved without tap");

	cnt_inc_a: assert property (
		global_operation_enable && counter_run_bit && tap9
		|=> cnt_reg == $past(cnt_reg) + wit_cnt_t'(1))
		else $error("counter missed a tap");

	// overflow wraps to zero so the long period repeats exactly
	cnt_wrap_a: assert property (
		global_operation_enable && counter_run_bit && tap9 && cnt_reg == 5'h1F
		|=> cnt_reg == '0)
		else $error("counter did not wrap on overflow");

	watch_mid_a: assert property (
		watch_interrupt && $past(wsel) == WIT_WP_2P13
		|-> $past(cnt_reg[3:0]) == 4'hF && $past(presc_reg[8:0]) == 9'h1FF)
		else $error("2^13 watch period off its count");

	watch_tap5_a: assert property (
		watch_interrupt && $past(wsel) == WIT_WP_2P5 |-> $past(presc_reg[4:0]) == 5'h1F)
		else $error("2^5 watch period off its tap");

	// a completed period is never lost while running
	watch_fire_a: assert property (
		global_operation_enable && counter_run_bit && watch_fire |=> watch_interrupt)
		else $error("watch period ended without interrupt");

	intv_fire_a: assert property (
		global_operation_enable && interval_fire |=> interval_interrupt)
		else $error("interval ended without interrupt");

	// stopped timer stays silent on both outputs
	stop_quiet_a: assert property (
		!global_operation_enable |=> !watch_interrupt && !interval_interrupt)
		else $error("interrupt while stopped");

	intv_long_a: assert property (
		interval_interrupt && $past(isel) == 3'h7 |-> $past(presc_reg) == 11'h7FF)
		else $error("2^11 interval off its tap");

	intv_short_a: assert property (
		interval_interrupt && $past(isel) == 3'h0 |-> $past(presc_reg[3:0]) == 4'hF)
		else $error("2^4 interval off its tap");

endmodule

// ---- design/wit_map.svh ----
// constants of the watch and interval timer: bit positions, reset values, taps
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH

// mode register layout
`define WIT_MODE_W          8
`define WIT_MODE_RESET      8'h00
`define WIT_BIT_GLOBAL_EN   0
`define WIT_BIT_RUN         1
`define WIT_BIT_WSEL_LO     2
`define WIT_BIT_WSEL_HI     3
`define WIT_BIT_ISEL_LO     4
`define WIT_BIT_ISEL_HI     6
`define WIT_BIT_CLK_SRC     7

// counter widths
`define WIT_PRESC_W         11
`define WIT_CNT_W           5

// peripheral clock divided by 2^7 gives the watch clock
`define WIT_PRS_DIV         128
`define WIT_PRS_DIV_W       7

// prescaler taps, in powers of two of the watch clock
`define WIT_TAP_COUNTER     9
`define WIT_TAP_SHORT       4
`define WIT_TAP_LONG        5
`define WIT_ITAP_BASE       4

// counter end values for the long watch periods
`define WIT_CNT_END_14      5'h1F
`define WIT_CNT_END_13      4'hF

`endif

// ---- design/wit_pkg.sv ----
// types shared by the watch and interval timer
package wit_pkg;

	// watch interrupt period selection
	typedef enum logic [1:0]
	{
		WIT_WP_2P14 = 2'h0,
		WIT_WP_2P13 = 2'h1,
		WIT_WP_2P5  = 2'h2,
		WIT_WP_2P4  = 2'h3
	} wit_wsel_t;

	typedef logic [10:0] wit_presc_t;
	typedef logic [4:0]  wit_cnt_t;

endpackage

// ---- design/wit_tick_div.sv ----
// clock-enable divider: one-cycle tick every DIV clocks, restarted by clr
`include "wit_map.svh"

module wit_tick_div
	import wit_pkg::*;
#(
	parameter int DIV   = `WIT_PRS_DIV,
	parameter int CNT_W = `WIT_PRS_DIV_W
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clr,
	output logic      tick
);

	logic [CNT_W-1:0] div_reg;

	// free count; clr restarts the phase so a fresh start is repeatable
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_reg <= '0;
		else if (clr)
			div_reg <= '0;
		else if (div_reg == CNT_W'(DIV - 1))
			div_reg <= '0;
		else
			div_reg <= div_reg + CNT_W'(1);
	end

	assign tick = !clr && (div_reg == CNT_W'(DIV - 1));

endmodule

// ---- bench/wit_irq_model.sv ----
// interrupt-side model: counts the pulses that reach the controller
module wit_irq_model
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic watch_interrupt,
	input  wire logic interval_interrupt,
	output int        n_watch,
	output int        n_ival
);
	timeunit 1ns;
	timeprecision 1ps;
	// one count per high cycle, so a stretched pulse shows as extra requests
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			n_watch <= 0;
			n_ival  <= 0;
		end
		else
		begin
			n_watch <= n_watch + int'(watch_interrupt === 1'b1);
			n_ival  <= n_ival + int'(interval_interrupt === 1'b1);
		end
	end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench of the watch and interval timer
`include "wit_map.svh"

module testbench
	import wit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk;
	logic                    rst_n;
	logic                    mode_wr;
	logic [`WIT_MODE_W-1:0]  mode_wdata;
	logic                    sub_clk = 1'b0;
	logic [`WIT_MODE_W-1:0]  mode_rdata;
	logic [`WIT_PRESC_W-1:0] presc_value;
	logic [`WIT_CNT_W-1:0]   cnt_value;
	logic                    watch_interrupt;
	logic                    interval_interrupt;
	bit                      sub_on = 1'b0;
	int                      n_watch;
	int                      n_ival;
	int                      cyc = 0;
	int                      n_fail = 0;
	int                      cmp_count = 0;

	wit_core dut (.clk, .rst_n, .mode_wr, .mode_wdata, .sub_clk, .mode_rdata,
		.presc_value, .cnt_value, .watch_interrupt, .interval_interrupt);
	wit_irq_model irq (.clk, .rst_n, .watch_interrupt, .interval_interrupt,
		.n_watch, .n_ival);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// subsystem clock at half the system rate, low while unused
	always @(negedge clk)
	begin
		sub_clk <= sub_on ? ~sub_clk : 1'b0;
		cyc     <= cyc + 1;
	end

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		mode_wr    = 1'b1;
		mode_wdata = d;
		@(negedge clk);
		mode_wr    = 1'b0;
	endtask

	// bounded wait for a pulse; stamps its cycle and checks it is one cycle wide
	task automatic wait_irq(input bit w, input int lim, output int t);
		int k;
		for (k = 0; k < lim; k++)
		begin
			@(negedge clk);
			if ((w ? watch_interrupt : interval_interrupt) === 1'b1)
				break;
		end
		if (k == lim)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, 0, 1);
			tally_and_finish();
		end
		t = cyc;
		@(negedge clk);
		chk(w ? watch_interrupt : interval_interrupt, 0);
	endtask

	// interval on the divided system clock, global enable only
	task automatic s_prs;
		int t0, t1, nb;
		chk(mode_rdata, 0);
		wr(8'h01);
		chk(mode_rdata, 8'h01);
		nb = n_ival;
		wait_irq(0, 3000, t0);
		wait_irq(0, 3000, t1);
		chk(t1 - t0, 16 * `WIT_PRS_DIV);
		chk(n_ival - nb, 2);
		chk(cnt_value, 0);
		wr(8'h00);
		@(negedge clk);
		chk(presc_value, 0);
	endtask

	// every interval code on the subsystem clock; fields change only while stopped
	task automatic s_ival;
		int s, t0, t1;
		sub_on = 1'b1;
		for (s = 0; s < 8; s++)
		begin
			wr(8'h80 | (s << 4));
			wr(8'h81 | (s << 4));
			wait_irq(0, 5000, t0);
			wait_irq(0, 5000, t1);
			chk(t1 - t0, 2 << (4 + s));
			wr(8'h80);
		end
	endtask

	// every watch code, then run-only restart and full stop
	task automatic s_watch;
		int ord[4] = '{3, 2, 0, 1};
		int i, ws, p, d, t0, t1;
		for (i = 0; i < 4; i++)
		begin
			ws = ord[i];
			p  = ws > 1 ? (16 << (3 - ws)) : (8192 << (1 - ws));
			wr(8'h83 | (ws << 2));
			t0 = cyc;
			wait_irq(1, 40000, t1);
			d = t1 - t0;
			if (ws > 1)
			begin
				wait_irq(1, 200, t0);
				chk(t0 - t1, 2 * p);
			end
			else
				chk(d >= 2 * p - 8 && d <= 2 * (p + 512) + 8, 1);
			if (ws != 1)
				wr(8'h80);
		end
		p = presc_value;
		wr(8'h85);
		@(negedge clk);
		chk(cnt_value, 0);
		repeat (20) @(negedge clk);
		chk(presc_value != p, 1);
		wr(8'h87);
		t0 = cyc;
		wait_irq(1, 20000, t1);
		d = t1 - t0;
		chk(d >= 2 * (8192 - 512) - 8 && d <= 2 * (8192 + 512) + 8, 1);
		wr(8'h00);
		@(negedge clk);
		chk(cnt_value, 0);
		chk(presc_value, 0);
	endtask

	initial
	begin
		rst_n      = 1'b0;
		mode_wr    = 1'b0;
		mode_wdata = 8'h00;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		s_prs();
		s_ival();
		s_watch();
		tally_and_finish();
	end
endmodule
